// ===== verilog/option_pkg.sv
// Constants and field layouts for the write-once option registers
package option_pkg;

   // Register indices; the Wishbone byte address is four times the index
   localparam logic [7:0] PIN_CLOCK_IDX = 8'h1e;
   localparam logic [7:0] SUPERVISOR_IDX = 8'h1f;

   // Reset values
   localparam logic [7:0] SUPERVISOR_RST = 8'h00;
   localparam logic [7:0] PIN_CLOCK_RST = 8'h00;

   // Bits that survive ordinary resets
   localparam int TRIP_LEVEL_BIT = 3;
   localparam int RESET_PIN_BIT = 0;

   // Reserved bits of the pin and clock register read as zero
   localparam logic [7:0] PIN_CLOCK_MASK = 8'hdb;

   // Cycle counts in four-times bus clock cycles
   localparam int STOP_SHORT_CYCLES = 32;
   localparam int STOP_LONG_CYCLES = 4096;
   localparam int WDOG_SHORT_CYCLES = 8176;
   localparam int WDOG_LONG_CYCLES = 262128;

   typedef struct packed {
      logic watchdog_period_select;
      logic supply_monitor_in_stop;
      logic supply_monitor_reset_disable;
      logic supply_monitor_power_disable;
      logic supply_monitor_trip_level;
      logic short_stop_recovery;
      logic stop_enable;
      logic watchdog_disable;
   } supervisor_options_s;

   typedef struct packed {
      logic interrupt_pin_pullup_off;
      logic interrupt_pin_function_on;
      logic rsvd5;
      logic timer_channel_position;
      logic serial_port_clock_source;
      logic rsvd2;
      logic oscillator_in_stop;
      logic reset_pin_function_on;
   } pin_and_clock_options_s;

   typedef struct packed {
      logic port_b_pin_1;
      logic port_b_pin_2;
      logic port_b_pin_4;
      logic port_b_pin_5;
   } timer_route_s;

endpackage

// ===== verilog/delay_timer.sv
// Down-counting one-shot delay used for stop recovery
`timescale 1ns/1ps
module delay_timer #(
   parameter int WIDTH = 13
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire logic [WIDTH-1:0] count_i,
   output logic busy_o,
   output logic done_o
);

   initial begin
      if (WIDTH < 2) begin
         $error("delay_timer WIDTH too small");
      end
   end

   logic [WIDTH-1:0] cnt_r;
   logic busy_r;
   logic done_r;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_r <= '0;
         busy_r <= 1'b0;
      end else if (start_i) begin
         cnt_r <= count_i - WIDTH'(1);
         busy_r <= 1'b1;
      end else if (busy_r) begin
         if (cnt_r == '0) begin
            busy_r <= 1'b0;
         end else begin
            cnt_r <= cnt_r - WIDTH'(1);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         done_r <= 1'b0;
      end else begin
         done_r <= busy_r && !start_i && (cnt_r == '0);
      end
   end

   assign busy_o = busy_r;
   assign done_o = done_r;

endmodule

// ===== verilog/write_once_option_config.sv
// Write-once option registers with the logic they steer
// Notes on behaviour
// - One write per register after each reset
// - Registers at 001E/001F, always readable
// - Trip level cleared by power-on only
// - Reset-pin bit power-on cleared; enables pin
// - Pull-up bit one disconnects pull-up
// - Interrupt-pin bit one enables pin function
// - Timer channels on B4/B5 or B1/B2
// - Serial clock: bus clock or four-times clock
// - Oscillator bit keeps clock running in stop
// - Watchdog timeout 8176 or 262128 cycles
// - Monitor runs in stop if powered, enabled
// - Reset-disable bit blocks monitor resets
// - Power-disable bit switches monitor off
// - Trip level selects 5 V or 3.3 V
// - Stop recovery 32 or 4096 cycles
// - Monitor reset wake uses long recovery
// - Stop instruction illegal when not enabled
// - Watchdog disable bit turns watchdog off
//
// Local design decisions: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
module write_once_option_config #(
   parameter int WDOG_SHORT = option_pkg::WDOG_SHORT_CYCLES,
   parameter int WDOG_LONG = option_pkg::WDOG_LONG_CYCLES,
   parameter int WDOG_WIDTH = 18
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic por_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Processor events
   input wire logic stop_instr_i,
   input wire logic wake_i,
   input wire logic watchdog_service_i,
   input wire logic supply_trip_i,
   output logic stop_mode_o,
   output logic illegal_opcode_o,
   output logic stop_recovered_o,
   output logic oscillator_run_o,
   output logic watchdog_reset_o,
   // Supply monitor control
   output logic monitor_power_on_o,
   output logic monitor_active_o,
   output logic monitor_trip_5v_o,
   output logic monitor_reset_o,
   // Pin and clock steering
   output logic interrupt_pullup_on_o,
   output logic interrupt_pin_on_o,
   output logic reset_pin_on_o,
   output option_pkg::timer_route_s timer_route_o,
   output logic serial_clk_from_bus_o
);

   localparam int STOP_W = 13;

   initial begin
      if (WDOG_WIDTH < 2 || WDOG_SHORT < 2 || WDOG_LONG < 2 ||
         WDOG_SHORT >= (1 << WDOG_WIDTH) || WDOG_LONG >= (1 << WDOG_WIDTH))
      begin
         $error("watchdog parameters out of range");
      end
   end

   typedef enum logic [1:0] {
      RUN,
      STOPPED,
      RECOVER
   } stop_state_e;

   function automatic logic [7:0] byte_addr(input logic [7:0] idx);
      byte_addr = {idx[5:0], 2'b00};
   endfunction

   // Any reset source
   logic any_rst;
   assign any_rst = rst_i | por_i;

   // Wishbone slave: one wait state, ack one cycle after the strobe
   logic ack_r;
   logic [31:0] rdata_r;
   logic take;
   logic hit_sup;
   logic hit_pin;
   logic wr_sup;
   logic wr_pin;
   assign take = wb_cyc_i & wb_stb_i & ~ack_r;
   assign hit_sup = (wb_adr_i == byte_addr(option_pkg::SUPERVISOR_IDX));
   assign hit_pin = (wb_adr_i == byte_addr(option_pkg::PIN_CLOCK_IDX));
   // Register file
   option_pkg::supervisor_options_s sup_r;
   option_pkg::pin_and_clock_options_s pin_r;
   logic sup_written_r;
   logic pin_written_r;
   assign wr_sup = take & wb_we_i & wb_sel_i[0] & hit_sup & ~sup_written_r;
   assign wr_pin = take & wb_we_i & wb_sel_i[0] & hit_pin & ~pin_written_r;
   always_ff @(posedge clk_i) begin
      if (any_rst) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= take;
      end
   end

   // Reads are always served; unmapped addresses read zero
   always_ff @(posedge clk_i) begin
      if (any_rst) begin
         rdata_r <= 32'h0000_0000;
      end else if (take) begin
         if (hit_sup) begin
            rdata_r <= {24'h00_0000, sup_r};
         end else if (hit_pin) begin
            rdata_r <= {24'h00_0000, pin_r & option_pkg::PIN_CLOCK_MASK};
         end else begin
            rdata_r <= 32'h0000_0000;
         end
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdata_r;

   // Write-once locks, released by every reset
   always_ff @(posedge clk_i) begin
      if (any_rst) begin
         sup_written_r <= 1'b0;
      end else if (wr_sup) begin
         sup_written_r <= 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (any_rst) begin
         pin_written_r <= 1'b0;
      end else if (wr_pin) begin
         pin_written_r <= 1'b1;
      end
   end

   // Later writes are acked but change nothing
   always_ff @(posedge clk_i) begin
      if (por_i) begin
         sup_r <= option_pkg::SUPERVISOR_RST;
      end else if (rst_i) begin
         sup_r <= option_pkg::SUPERVISOR_RST;
         // Trip level keeps its value across ordinary resets
         sup_r.supply_monitor_trip_level <=
            sup_r.supply_monitor_trip_level;
      end else if (wr_sup) begin
         sup_r <= wb_dat_i[7:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (por_i) begin
         pin_r <= option_pkg::PIN_CLOCK_RST;
      end else if (rst_i) begin
         pin_r <= option_pkg::PIN_CLOCK_RST;
         pin_r.reset_pin_function_on <=
            pin_r.reset_pin_function_on;
      end else if (wr_pin) begin
         pin_r <= wb_dat_i[7:0] & option_pkg::PIN_CLOCK_MASK;
      end
   end

   // Supply trip input synchroniser
   logic trip_meta_r;
   logic trip_sync_r;
   always_ff @(posedge clk_i) begin
      if (any_rst) begin
         trip_meta_r <= 1'b0;
         trip_sync_r <= 1'b0;
      end else begin
         trip_meta_r <= supply_trip_i;
         trip_sync_r <= trip_meta_r;
      end
   end

   // Stop mode sequencing
   stop_state_e state_r;
   stop_state_e state_nxt;
   logic rec_start;
   logic [STOP_W-1:0] rec_count;
   logic rec_done;
   logic monitor_on;
   logic monitor_run;
   logic monitor_rst;
   logic illegal_r;
   assign monitor_on = ~sup_r.supply_monitor_power_disable;
   // Monitor runs outside stop, or in stop when enabled for it
   assign monitor_run = monitor_on &
      ((state_r == RUN) | sup_r.supply_monitor_in_stop);
   assign monitor_rst = monitor_run & trip_sync_r &
      ~sup_r.supply_monitor_reset_disable;

   always_comb begin
      state_nxt = state_r;
      rec_start = 1'b0;
      rec_count = STOP_W'(option_pkg::STOP_LONG_CYCLES);
      unique case (state_r)
         RUN: begin
            if (stop_instr_i && sup_r.stop_enable) begin
               state_nxt = STOPPED;
            end
         end
         STOPPED: begin
            if (monitor_rst) begin
               rec_start = 1'b1;
               rec_count = STOP_W'(option_pkg::STOP_LONG_CYCLES);
               state_nxt = RECOVER;
            end else if (wake_i) begin
               rec_start = 1'b1;
               if (sup_r.short_stop_recovery) begin
                  rec_count = STOP_W'(option_pkg::STOP_SHORT_CYCLES);
               end else begin
                  rec_count = STOP_W'(option_pkg::STOP_LONG_CYCLES);
               end
               state_nxt = RECOVER;
            end
         end
         RECOVER: begin
            if (rec_done) begin
               state_nxt = RUN;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (any_rst) begin
         state_r <= RUN;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (any_rst) begin
         illegal_r <= 1'b0;
      end else begin
         illegal_r <= stop_instr_i & ~sup_r.stop_enable;
      end
   end

   delay_timer #(
      .WIDTH(STOP_W)
   ) u_recovery (
      .clk_i(clk_i),
      .rst_i(any_rst),
      .start_i(rec_start),
      .count_i(rec_count),
      .busy_o(),
      .done_o(rec_done)
   );

   // Watchdog timeout counter; held clear while stopped or disabled
   logic [WDOG_WIDTH-1:0] wdog_cnt_r;
   logic [WDOG_WIDTH-1:0] wdog_limit;
   logic wdog_on;
   logic wdog_fire_r;
   assign wdog_on = ~sup_r.watchdog_disable;
   assign wdog_limit = sup_r.watchdog_period_select ?
      WDOG_WIDTH'(WDOG_SHORT - 1) : WDOG_WIDTH'(WDOG_LONG - 1);
   always_ff @(posedge clk_i) begin
      if (any_rst) begin
         wdog_cnt_r <= '0;
      end else if (!wdog_on || watchdog_service_i || state_r != RUN) begin
         wdog_cnt_r <= '0;
      end else if (wdog_cnt_r >= wdog_limit) begin
         wdog_cnt_r <= '0;
      end else begin
         wdog_cnt_r <= wdog_cnt_r + WDOG_WIDTH'(1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (any_rst) begin
         wdog_fire_r <= 1'b0;
      end else begin
         wdog_fire_r <= wdog_on & ~watchdog_service_i & (state_r == RUN) &
            (wdog_cnt_r >= wdog_limit);
      end
   end

   // Registered steering outputs
   logic osc_r;
   logic mon_pwr_r;
   logic mon_act_r;
   logic mon_trip_r;
   logic mon_rst_r;
   logic pull_r;
   logic irq_r;
   logic rstpin_r;
   logic serial_r;
   option_pkg::timer_route_s route_r;

   always_ff @(posedge clk_i) begin
      if (any_rst) begin
         osc_r <= 1'b1;
      end else begin
         osc_r <= (state_nxt == RUN) | (state_nxt == RECOVER) |
            pin_r.oscillator_in_stop;
      end
   end

   always_ff @(posedge clk_i) begin
      if (any_rst) begin
         mon_pwr_r <= 1'b0;
         mon_act_r <= 1'b0;
         mon_rst_r <= 1'b0;
      end else begin
         mon_pwr_r <= monitor_on;
         mon_act_r <= monitor_run;
         mon_rst_r <= monitor_rst;
      end
   end

   // Trip level and reset-pin outputs are cleared by power-on only
   always_ff @(posedge clk_i) begin
      if (por_i) begin
         mon_trip_r <= 1'b0;
         rstpin_r <= 1'b0;
      end else begin
         mon_trip_r <= sup_r.supply_monitor_trip_level;
         rstpin_r <= pin_r.reset_pin_function_on;
      end
   end

   always_ff @(posedge clk_i) begin
      if (any_rst) begin
         pull_r <= 1'b1;
         irq_r <= 1'b0;
         serial_r <= 1'b0;
         route_r <= '{port_b_pin_1: 1'b1, port_b_pin_2: 1'b1, default: 1'b0};
      end else begin
         pull_r <= ~pin_r.interrupt_pin_pullup_off;
         irq_r <= pin_r.interrupt_pin_function_on;
         serial_r <= pin_r.serial_port_clock_source;
         route_r.port_b_pin_4 <= pin_r.timer_channel_position;
         route_r.port_b_pin_5 <= pin_r.timer_channel_position;
         route_r.port_b_pin_1 <= ~pin_r.timer_channel_position;
         route_r.port_b_pin_2 <= ~pin_r.timer_channel_position;
      end
   end

   assign stop_mode_o = (state_r != RUN);
   assign illegal_opcode_o = illegal_r;
   assign stop_recovered_o = rec_done;
   assign oscillator_run_o = osc_r;
   assign watchdog_reset_o = wdog_fire_r;
   assign monitor_power_on_o = mon_pwr_r;
   assign monitor_active_o = mon_act_r;
   assign monitor_trip_5v_o = mon_trip_r;
   assign monitor_reset_o = mon_rst_r;
   assign interrupt_pullup_on_o = pull_r;
   assign interrupt_pin_on_o = irq_r;
   assign reset_pin_on_o = rstpin_r;
   assign timer_route_o = route_r;
   assign serial_clk_from_bus_o = serial_r;

endmodule

// ===== dv/write_once_option_config_assertions.sv
// Checker for the write-once option register block
`timescale 1ns/1ps
module write_once_option_config_assertions #(
   parameter int WDOG_SHORT = 8176,
   parameter int WDOG_LONG = 262128
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic por_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic [31:0] wb_dat_o,
   input wire logic stop_instr_i,
   input wire logic wake_i,
   input wire logic stop_mode_o,
   input wire logic illegal_opcode_o,
   input wire logic stop_recovered_o,
   input wire logic watchdog_reset_o,
   input wire logic interrupt_pullup_on_o,
   input wire logic reset_pin_on_o,
   input wire option_pkg::timer_route_s timer_route_o
);
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i || por_i);
   int wd_cnt;
   int wake_cnt;
   // Cycles since the last watchdog pulse and since the last wake
   always_ff @(posedge clk_i) begin
      if (rst_i || por_i || watchdog_reset_o)
         wd_cnt <= 0;
      else
         wd_cnt <= wd_cnt + 1;
   end
   always_ff @(posedge clk_i) begin
      if (rst_i || por_i || (wake_i && stop_mode_o))
         wake_cnt <= 0;
      else if (wake_cnt < 100000)
         wake_cnt <= wake_cnt + 1;
   end
   sequence s_wb_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_stop_exit;
      stop_mode_o ##1 !stop_mode_o;
   endsequence
   a_ack_after_take: assert property (s_wb_take |=> wb_ack_o)
      else $error("no ack one cycle after request");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_read_upper_zero: assert property (
      wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
      else $error("upper read data not zero");
   a_stop_answer: assert property (
      stop_instr_i && !stop_mode_o |=> stop_mode_o != illegal_opcode_o)
      else $error("stop instruction got no single answer");
   a_illegal_cause: assert property (
      illegal_opcode_o |-> $past(stop_instr_i))
      else $error("illegal opcode without stop instruction");
   a_recover_exit: assert property (
      stop_recovered_o |-> s_stop_exit)
      else $error("stop mode not left after recovery");
   a_recover_delay: assert property (
      stop_recovered_o |-> wake_cnt >= option_pkg::STOP_SHORT_CYCLES)
      else $error("stop recovery too early");
   a_wdog_gap: assert property (
      watchdog_reset_o |-> wd_cnt >= WDOG_SHORT - 1)
      else $error("watchdog pulse too early");
   a_timer_pair: assert property (
      timer_route_o == 4'hc || timer_route_o == 4'h3)
      else $error("timer channels not on one pin pair");
   a_reset_quiet: assert property (disable iff (1'b0)
      (rst_i || por_i) [*2] |-> !wb_ack_o && !stop_mode_o &&
      interrupt_pullup_on_o)
      else $error("outputs active during reset");
   a_por_clears: assert property (disable iff (1'b0)
      por_i [*2] |-> !reset_pin_on_o)
      else $error("reset pin function kept through power-on");
endmodule

bind write_once_option_config write_once_option_config_assertions #(
   .WDOG_SHORT(WDOG_SHORT), .WDOG_LONG(WDOG_LONG)
) write_once_option_config_assertions_inst (
   .clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
   .stop_instr_i(stop_instr_i), .wake_i(wake_i), .stop_mode_o(stop_mode_o),
   .illegal_opcode_o(illegal_opcode_o), .stop_recovered_o(stop_recovered_o),
   .watchdog_reset_o(watchdog_reset_o),
   .interrupt_pullup_on_o(interrupt_pullup_on_o),
   .reset_pin_on_o(reset_pin_on_o), .timer_route_o(timer_route_o)
);

// ===== dv/test_write_once_option_config.sv
// Testbench for the write-once option register block
`timescale 1ns/1ps
module test_write_once_option_config;
   localparam int WDS = 20;
   localparam int WDL = 40;
   logic clk_i, rst_i, por_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, q;
   logic stop_instr_i, wake_i, watchdog_service_i, supply_trip_i;
   logic stop_mode_o, illegal_opcode_o, stop_recovered_o, oscillator_run_o;
   logic watchdog_reset_o, monitor_power_on_o, monitor_active_o;
   logic monitor_trip_5v_o, monitor_reset_o, interrupt_pullup_on_o;
   logic interrupt_pin_on_o, reset_pin_on_o, serial_clk_from_bus_o;
   option_pkg::timer_route_s timer_route_o;
   int miscompares, cmp_count, g;

   write_once_option_config #(.WDOG_SHORT(WDS), .WDOG_LONG(WDL))
      write_once_option_config_inst (
      .clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .stop_instr_i(stop_instr_i), .wake_i(wake_i),
      .watchdog_service_i(watchdog_service_i), .supply_trip_i(supply_trip_i),
      .stop_mode_o(stop_mode_o), .illegal_opcode_o(illegal_opcode_o),
      .stop_recovered_o(stop_recovered_o), .oscillator_run_o(oscillator_run_o),
      .watchdog_reset_o(watchdog_reset_o),
      .monitor_power_on_o(monitor_power_on_o),
      .monitor_active_o(monitor_active_o),
      .monitor_trip_5v_o(monitor_trip_5v_o), .monitor_reset_o(monitor_reset_o),
      .interrupt_pullup_on_o(interrupt_pullup_on_o),
      .interrupt_pin_on_o(interrupt_pin_on_o), .reset_pin_on_o(reset_pin_on_o),
      .timer_route_o(timer_route_o),
      .serial_clk_from_bus_o(serial_clk_from_bus_o)
   );

   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // Classic single cycle; held until ack is sampled, then one idle cycle
   task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d,
                     input logic [3:0] s);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= {24'h0, d};
      wb_sel_i <= s;
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      wb(1'b0, a, 8'h00, 4'hf);
      check(q, {24'h0, exp});
   endtask

   task automatic reset_pulse(input logic p);
      rst_i <= !p;
      por_i <= p;
      tick(2);
      rst_i <= 1'b0;
      por_i <= 1'b0;
      tick(3);
   endtask

   // Edges between two watchdog pulses
   task automatic wd_gap;
      g = 0;
      while (watchdog_reset_o !== 1'b1 && g < 500) begin
         @(posedge clk_i);
         g++;
      end
      g = 0;
      do begin
         @(posedge clk_i);
         g++;
      end while (watchdog_reset_o !== 1'b1 && g < 500);
   endtask

   task automatic stop_pulse;
      stop_instr_i <= 1'b1;
      @(posedge clk_i);
      stop_instr_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task close_out;
      $display("Compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial begin
      tick(20000);
      miscompares++;
      close_out;
   end

   initial begin
      {rst_i, por_i} = 2'b11;
      {wb_cyc_i, wb_stb_i, wb_we_i, stop_instr_i, wake_i} = 5'h00;
      {watchdog_service_i, supply_trip_i} = 2'b00;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h0;
      tick(5);
      rst_i <= 1'b0;
      por_i <= 1'b0;
      tick(3);
      rdc(8'h78, 8'h00);
      rdc(8'h7c, 8'h00);
      check(interrupt_pullup_on_o, 1'b1);
      check(timer_route_o, 4'b1100);
      check({interrupt_pin_on_o, serial_clk_from_bus_o}, 2'b00);
      wb(1'b1, 8'h78, 8'hff, 4'hf);
      wb(1'b1, 8'h78, 8'h00, 4'hf);
      rdc(8'h78, 8'hdb);
      rdc(8'h40, 8'h00);
      wb(1'b1, 8'h7c, 8'hff, 4'h0);
      wb(1'b1, 8'h7c, 8'h8e, 4'hf);
      wb(1'b1, 8'h7c, 8'h00, 4'hf);
      rdc(8'h7c, 8'h8e);
      tick(2);
      check(interrupt_pullup_on_o, 1'b0);
      check(interrupt_pin_on_o, 1'b1);
      check(timer_route_o, 4'b0011);
      check(serial_clk_from_bus_o, 1'b1);
      check(reset_pin_on_o, 1'b1);
      check({monitor_trip_5v_o, monitor_power_on_o}, 2'b11);
      wd_gap;
      check(g, WDS);
      stop_pulse;
      check(stop_mode_o, 1'b1);
      tick(3);
      check(oscillator_run_o, 1'b1);
      wake_i <= 1'b1;
      @(posedge clk_i);
      wake_i <= 1'b0;
      g = 0;
      do begin
         @(posedge clk_i);
         g++;
      end while (stop_recovered_o !== 1'b1 && g < 5000);
      check(g, option_pkg::STOP_SHORT_CYCLES + 1);
      @(posedge clk_i);
      check(stop_mode_o, 1'b0);
      reset_pulse(1'b0);
      rdc(8'h78, 8'h01);
      rdc(8'h7c, 8'h08);
      check({reset_pin_on_o, monitor_trip_5v_o}, 2'b11);
      wd_gap;
      check(g, WDL);
      stop_pulse;
      check({illegal_opcode_o, stop_mode_o}, 2'b10);
      wb(1'b1, 8'h7c, 8'h21, 4'hf);
      supply_trip_i <= 1'b1;
      wd_gap;
      check(g, 500);
      check(monitor_reset_o, 1'b0);
      supply_trip_i <= 1'b0;
      reset_pulse(1'b1);
      rdc(8'h78, 8'h00);
      rdc(8'h7c, 8'h00);
      supply_trip_i <= 1'b1;
      tick(6);
      check(monitor_reset_o, 1'b1);
      supply_trip_i <= 1'b0;
      tick(6);
      // Monitor kept on in stop; its reset ends stop with the long delay
      wb(1'b1, 8'h7c, 8'h46, 4'hf);
      stop_pulse;
      tick(3);
      check(monitor_active_o, 1'b1);
      supply_trip_i <= 1'b1;
      g = 0;
      do begin
         @(posedge clk_i);
         g++;
      end while (stop_mode_o !== 1'b0 && g < 5000);
      check(g, option_pkg::STOP_LONG_CYCLES + 5);
      supply_trip_i <= 1'b0;
      reset_pulse(1'b1);
      wb(1'b1, 8'h7c, 8'h12, 4'hf);
      stop_pulse;
      check({oscillator_run_o, stop_mode_o}, 2'h1);
      tick(3);
      check({monitor_power_on_o, monitor_active_o}, 2'b00);
      close_out;
   end
endmodule
